// ---- logic/eeprom_majority_parity_lock.sv ----
// Function
// - Each parameter bit lives in three cells of one row, resolved by majority vote.
// - Cell array is four columns by 128 rows, parameters plus extra cells.
// - Parity fails only when a voted bit is wrong, two of three cells flipped.
// - Parity fault drives output low rail if fault level select 0, high if 1.
// - A parity fault overrides normal output and holds the diagnostic level.
// - Customer serial bits are single cells, not triple redundant.
// - Extra cells never influence device operation, whatever they hold.
// - Factory check bits are stored beside factory data for programmer verification.
// - Two-bit amplifier configuration field, factory value 1, selects output current capacity.
// - With the lock bit set, programming entry and every write are refused.
// - Raising supply to the programming level puts the device in programming mode.
// - Programming data arrives on the output pin as a three-level self-clocked stream.
// - Each bit is captured at the leading edge of its bit period.
// - A read command makes the device send memory contents by supply current modulation.
// - Unique factory identifier of lot, wafer, die X and Y, plus user serial memory.
// - Read back works whether or not the lock bit is set.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////

module word_fifo #(
  parameter int unsigned WIDTH = 4,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slot;
    logic [PTR_W-1:0]            wptr;
    logic [PTR_W-1:0]            rptr;
    logic [CNT_W-1:0]            count;
  } fifo_s;

  fifo_s s_r;
  fifo_s s_nxt;
  logic  push;
  logic  pop;

  assign in_ready  = (s_r.count != CNT_W'(DEPTH));
  assign out_valid = (s_r.count != '0);
  assign out_data  = s_r.slot[s_r.rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.slot[s_r.wptr] = in_data;
      s_nxt.wptr = (s_r.wptr == PTR_W'(DEPTH - 1)) ? '0 : s_r.wptr + PTR_W'(1);
    end
    if (pop) begin
      s_nxt.rptr = (s_r.rptr == PTR_W'(DEPTH - 1)) ? '0 : s_r.rptr + PTR_W'(1);
    end
    if (push && !pop) begin
      s_nxt.count = s_r.count + CNT_W'(1);
    end else if (pop && !push) begin
      s_nxt.count = s_r.count - CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  fifo_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_r.count == CNT_W'(DEPTH)) |-> (!in_ready ##1 (s_r.count <= CNT_W'(DEPTH))))
    else $error("fifo accepted a word while full");

endmodule : word_fifo

////////////////////////////////////////////////////////////////////////////////

module eeprom_majority_parity_lock #(
  parameter logic [31:0]  FACTORY_ID_INIT = 32'h1234_5678,   // Arbitrary value.
  parameter int unsigned  RB_BIT_CYCLES   = eeprom_pkg::RB_BIT_CYC
) (
  input  wire logic                                  pclk,
  input  wire logic                                  presetn,
  input  wire eeprom_pkg::apb_req_s                  apb_req,
  output eeprom_pkg::apb_rsp_s                       apb_rsp,
  input  wire logic                                  supply_prog_det,
  input  wire logic                                  pin_above_high,
  input  wire logic                                  pin_below_low,
  output logic                                       supply_current_mod,
  output logic                                       prog_mode,
  output logic                                       out_diag_active,
  output logic                                       out_diag_high,
  output logic [eeprom_pkg::AMP_MODE_W-1:0]          out_amp_mode,
  output logic [eeprom_pkg::PARAM_BITS-1:0]          param_word
);

  typedef struct packed {
    eeprom_pkg::mem_t                      mem;
    logic [eeprom_pkg::PARAM_BITS-1:0]     params;
    logic                                  diag;
    logic                                  load_pend;
    logic                                  prog;
    logic [2:0]                            det_s;
    logic [1:0]                            hi_s;
    logic [1:0]                            lo_s;
    logic [1:0]                            pin_prev;
    logic [eeprom_pkg::FRAME_BITS-1:0]     shreg;
    logic [3:0]                            bitcnt;
    eeprom_pkg::exec_e                     st;
    logic [eeprom_pkg::ROW_W-1:0]          dump_row;
    logic [eeprom_pkg::MEM_COLS-1:0]       tx_sh;
    logic [2:0]                            tx_cnt;
    logic                                  tx_bit;
    logic [eeprom_pkg::DIV_W-1:0]          div;
    logic [31:0]                           prdata;
    logic                                  pslverr;
  } core_s;

  // Majority of the three redundant cells of every parameter row.
  function automatic logic [eeprom_pkg::PARAM_BITS-1:0] vote(input eeprom_pkg::mem_t m);
    logic [eeprom_pkg::PARAM_BITS-1:0] v;
    v = '0;
    for (int i = 0; i < eeprom_pkg::PARAM_BITS; i++) begin
      v[i] = (m[i][0] & m[i][1]) | (m[i][0] & m[i][2]) | (m[i][1] & m[i][2]);
    end
    return v;
  endfunction : vote

  // Extra storage: column 3 of the parameter rows, then every cell of the upper rows.
  function automatic int unsigned extra_row(input int unsigned e);
    return (e < eeprom_pkg::PARAM_BITS) ? e : eeprom_pkg::PARAM_BITS + (e - eeprom_pkg::PARAM_BITS) / 4;
  endfunction : extra_row

  function automatic int unsigned extra_col(input int unsigned e);
    return (e < eeprom_pkg::PARAM_BITS) ? 3 : (e - eeprom_pkg::PARAM_BITS) % 4;
  endfunction : extra_col

  function automatic logic [eeprom_pkg::EXTRA_BITS-1:0] extra(input eeprom_pkg::mem_t m);
    logic [eeprom_pkg::EXTRA_BITS-1:0] x;
    x = '0;
    for (int unsigned e = 0; e < eeprom_pkg::EXTRA_BITS; e++) begin
      x[e] = m[extra_row(e)][extra_col(e)];
    end
    return x;
  endfunction : extra

  function automatic eeprom_pkg::mem_t init_mem(input logic [31:0] fid);
    eeprom_pkg::mem_t m;
    m = '0;
    for (int unsigned i = 0; i < eeprom_pkg::PARAM_BITS; i++) begin
      for (int unsigned c = 0; c < eeprom_pkg::VOTE_COLS; c++) begin
        m[i][c] = eeprom_pkg::PARAM_RESET[i];
      end
    end
    for (int unsigned k = 0; k < eeprom_pkg::FID_W; k++) begin
      m[extra_row(eeprom_pkg::FID_LSB + k)][extra_col(eeprom_pkg::FID_LSB + k)] = fid[k];
    end
    return m;
  endfunction : init_mem

  function automatic logic addr_known(input logic [7:0] a);
    return (a == eeprom_pkg::REG_STATUS) || (a == eeprom_pkg::REG_CTRL) ||
           (a == eeprom_pkg::REG_PARAM_LO) || (a == eeprom_pkg::REG_PARAM_HI) ||
           (a == eeprom_pkg::REG_SERIAL) || (a == eeprom_pkg::REG_FID) || (a == eeprom_pkg::REG_CHECK);
  endfunction : addr_known

  core_s                                 s_r;
  core_s                                 s_nxt;
  logic [eeprom_pkg::PARAM_BITS-1:0]     voted;
  logic [eeprom_pkg::EXTRA_BITS-1:0]     xbits;
  logic                                  lock_live;
  logic                                  pin_mid;
  logic                                  lead_edge;
  logic [eeprom_pkg::FRAME_BITS-1:0]     frame;
  logic                                  frame_done;
  logic                                  fifo_in_valid;
  logic                                  fifo_in_ready;
  logic                                  fifo_out_valid;
  logic                                  fifo_out_ready;
  logic [eeprom_pkg::MEM_COLS-1:0]       fifo_out_data;
  logic                                  rb_busy;

  assign voted      = vote(s_r.mem);
  assign xbits      = extra(s_r.mem);
  assign lock_live  = voted[eeprom_pkg::LOCK_BIT];
  assign pin_mid    = !s_r.hi_s[1] && !s_r.lo_s[1];
  // A bit starts when the pin leaves the middle level; the level it steps to is the bit.
  // Frames are heard whenever the supply sits at the programming level, so a locked part still reads back.
  assign lead_edge  = s_r.det_s[1] && (s_r.pin_prev == 2'h0) && !pin_mid;
  assign frame      = {s_r.shreg[eeprom_pkg::FRAME_BITS-2:0], s_r.hi_s[1]};
  assign frame_done = lead_edge && (s_r.bitcnt == 4'(eeprom_pkg::FRAME_BITS - 1));
  assign fifo_in_valid  = (s_r.st == eeprom_pkg::EX_DUMP);
  assign fifo_out_ready = (s_r.tx_cnt == 3'h0);
  // Words still queued count as busy, or the gap between two row words would look idle.
  assign rb_busy        = (s_r.st != eeprom_pkg::EX_IDLE) || fifo_out_valid || (s_r.tx_cnt != 3'h0);

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_nxt = s_r;
    s_nxt.det_s    = {s_r.det_s[1:0], supply_prog_det};
    s_nxt.hi_s     = {s_r.hi_s[0], pin_above_high};
    s_nxt.lo_s     = {s_r.lo_s[0], pin_below_low};
    s_nxt.pin_prev = {s_r.hi_s[1], s_r.lo_s[1]};

    // Programming entry and exit follow the supply level detector.
    if (!s_r.det_s[1]) begin
      if (s_r.prog) begin
        s_nxt.load_pend = 1'b1;
      end
      s_nxt.prog   = 1'b0;
      s_nxt.bitcnt = '0;
    end else if (s_r.det_s[1] && !s_r.det_s[2] && !lock_live) begin
      s_nxt.prog   = 1'b1;
      s_nxt.bitcnt = '0;
    end

    if (lead_edge) begin
      s_nxt.shreg  = frame;
      s_nxt.bitcnt = frame_done ? 4'h0 : s_r.bitcnt + 4'h1;
    end

    if (frame_done && s_r.prog && (frame[eeprom_pkg::OP_MSB -: 2] == eeprom_pkg::OP_WRITE) && !lock_live) begin
      s_nxt.mem[frame[eeprom_pkg::ROW_LSB +: eeprom_pkg::ROW_W]][frame[eeprom_pkg::COL_LSB +: eeprom_pkg::COL_W]] =
        frame[0];
    end

    unique case (s_r.st)
      eeprom_pkg::EX_IDLE: begin
        if (frame_done && (frame[eeprom_pkg::OP_MSB -: 2] == eeprom_pkg::OP_READ)) begin
          s_nxt.st       = eeprom_pkg::EX_DUMP;
          s_nxt.dump_row = '0;
        end
      end
      eeprom_pkg::EX_DUMP: begin
        if (fifo_in_ready) begin
          s_nxt.dump_row = s_r.dump_row + 7'h01;
          if (s_r.dump_row == 7'(eeprom_pkg::MEM_ROWS - 1)) begin
            s_nxt.st = eeprom_pkg::EX_IDLE;
          end
        end
      end
    endcase

    // Supply current modulator: one row word, most significant cell first.
    if (fifo_out_valid && fifo_out_ready) begin
      s_nxt.tx_sh  = fifo_out_data;
      s_nxt.tx_cnt = 3'(eeprom_pkg::MEM_COLS);
      s_nxt.tx_bit = fifo_out_data[eeprom_pkg::MEM_COLS-1];
      s_nxt.div    = '0;
    end else if (s_r.tx_cnt != 3'h0) begin
      if (s_r.div == eeprom_pkg::DIV_W'(RB_BIT_CYCLES - 1)) begin
        s_nxt.div    = '0;
        s_nxt.tx_sh  = {s_r.tx_sh[eeprom_pkg::MEM_COLS-2:0], 1'b0};
        s_nxt.tx_cnt = s_r.tx_cnt - 3'h1;
        s_nxt.tx_bit = (s_r.tx_cnt == 3'h1) ? 1'b0 : s_r.tx_sh[eeprom_pkg::MEM_COLS-2];
      end else begin
        s_nxt.div = s_r.div + eeprom_pkg::DIV_W'(1);
      end
    end

    // Parameter load: only voted rows reach the analogue side, extra cells never do.
    if (s_r.load_pend && !s_r.prog) begin
      s_nxt.params    = voted;
      s_nxt.diag      = ^voted;
      s_nxt.load_pend = 1'b0;
    end

    // APB: read data and error are prepared in the setup cycle, zero wait states.
    if (apb_req.psel && !apb_req.penable) begin
      s_nxt.pslverr = !addr_known(apb_req.paddr) || (apb_req.pwrite && (apb_req.paddr != eeprom_pkg::REG_CTRL));
      s_nxt.prdata  = '0;
      if (!apb_req.pwrite) begin
        unique case (apb_req.paddr)
          eeprom_pkg::REG_STATUS:   s_nxt.prdata = {27'h0, s_r.load_pend, rb_busy, lock_live, s_r.diag, s_r.prog};
          eeprom_pkg::REG_PARAM_LO: s_nxt.prdata = s_r.params[31:0];
          eeprom_pkg::REG_PARAM_HI: s_nxt.prdata = s_r.params[63:32];
          eeprom_pkg::REG_SERIAL:   s_nxt.prdata = {8'h00, xbits[eeprom_pkg::SERIAL_LSB +: eeprom_pkg::SERIAL_W]};
          eeprom_pkg::REG_FID:      s_nxt.prdata = xbits[eeprom_pkg::FID_LSB +: eeprom_pkg::FID_W];
          eeprom_pkg::REG_CHECK:    s_nxt.prdata = {24'h0, xbits[eeprom_pkg::CHECK_LSB +: eeprom_pkg::CHECK_W]};
          default:                  s_nxt.prdata = '0;
        endcase
      end
    end
    if (apb_req.psel && apb_req.penable && apb_req.pwrite && (apb_req.paddr == eeprom_pkg::REG_CTRL) &&
        apb_req.pwdata[eeprom_pkg::CTRL_RELOAD_BIT]) begin
      s_nxt.load_pend = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r           <= '0;
      s_r.mem       <= init_mem(FACTORY_ID_INIT);
      s_r.params    <= eeprom_pkg::PARAM_RESET;
      s_r.load_pend <= 1'b1;
      s_r.st        <= eeprom_pkg::EX_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  word_fifo #(
    .WIDTH (eeprom_pkg::MEM_COLS),
    .DEPTH (eeprom_pkg::FIFO_DEPTH)
  ) u_rb_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (s_r.mem[s_r.dump_row]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////////

  assign apb_rsp.prdata  = s_r.prdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = s_r.pslverr;
  assign supply_current_mod = s_r.tx_bit;
  assign prog_mode       = s_r.prog;
  assign out_diag_active = s_r.diag;
  assign out_diag_high   = s_r.diag && s_r.params[eeprom_pkg::FAULT_LEV_BIT];
  assign out_amp_mode    = s_r.params[eeprom_pkg::AMP_MODE_LSB +: eeprom_pkg::AMP_MODE_W];
  assign param_word      = s_r.params;

  ////////////////////////////////////////////////////////////////////////////////

  vote_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_r.load_pend && !s_r.prog) |=> (s_r.params == $past(voted) && !s_r.load_pend))
    else $error("loaded parameters differ from the voted cells");

  parity_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_r.load_pend && !s_r.prog) |=> (s_r.diag == (^s_r.params)))
    else $error("diagnostic flag does not match loaded parity");

  diag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_r.diag && !s_r.load_pend) |=> s_r.diag)
    else $error("diagnostic cleared without a reload");

  fault_rail_a: assert property (@(posedge pclk) disable iff (!presetn)
    out_diag_active |-> (out_diag_high == param_word[eeprom_pkg::FAULT_LEV_BIT]))
    else $error("diagnostic rail does not follow the fault level select");

  lock_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!s_r.prog && lock_live) |=> !s_r.prog)
    else $error("programming mode entered while locked");

  lock_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    lock_live |=> (s_r.mem == $past(s_r.mem)))
    else $error("memory changed while locked");

  prog_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_r.prog && !s_r.det_s[1]) |=> (!s_r.prog && s_r.load_pend))
    else $error("programming mode kept after supply dropped");

  bit_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
    (lead_edge && !frame_done && s_r.det_s[1]) |=> (s_r.bitcnt == $past(s_r.bitcnt) + 4'h1))
    else $error("leading edge did not capture a bit");

  read_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_done && s_r.st == eeprom_pkg::EX_IDLE && frame[eeprom_pkg::OP_MSB -: 2] == eeprom_pkg::OP_READ)
    |=> (s_r.st == eeprom_pkg::EX_DUMP && s_r.dump_row == 7'h00))
    else $error("read command did not start read back");

endmodule : eeprom_majority_parity_lock

// ---- logic/eeprom_pkg.sv ----
package eeprom_pkg;

  localparam int unsigned MEM_ROWS     = 128;
  localparam int unsigned MEM_COLS     = 4;
  localparam int unsigned VOTE_COLS    = 3;
  localparam int unsigned PARAM_BITS   = 64;
  localparam int unsigned EXTRA_BITS   = PARAM_BITS + (MEM_ROWS - PARAM_BITS) * MEM_COLS;
  localparam int unsigned ROW_W        = 7;
  localparam int unsigned COL_W        = 2;

  // Voted parameter field positions.
  localparam int unsigned FAULT_LEV_BIT = 0;
  localparam int unsigned LOCK_BIT      = 1;
  localparam int unsigned AMP_MODE_LSB  = 2;
  localparam int unsigned AMP_MODE_W    = 2;
  localparam int unsigned PARITY_BIT    = 63;

  // Amplifier configuration 1, parity bit set so that the whole word has even parity.
  localparam logic [PARAM_BITS-1:0] PARAM_RESET = 64'h8000_0000_0000_0004;

  // Extra storage field positions, in the flattened extra bit vector.
  localparam int unsigned SERIAL_LSB  = 0;
  localparam int unsigned SERIAL_W    = 24;
  localparam int unsigned FID_LSB     = 64;
  localparam int unsigned FID_W       = 32;
  localparam int unsigned CHECK_LSB   = 120;
  localparam int unsigned CHECK_W     = 8;

  // Serial frame: opcode, row, column, data; sent most significant bit first.
  localparam int unsigned FRAME_BITS  = 12;
  localparam int unsigned OP_MSB      = 11;
  localparam int unsigned ROW_LSB     = 3;
  localparam int unsigned COL_LSB     = 1;
  localparam logic [1:0]  OP_WRITE    = 2'h1;
  localparam logic [1:0]  OP_READ     = 2'h2;

  // Read-back bit period on the supply current.
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned RB_BIT_NS    = 1000;
  localparam int unsigned RB_BIT_CYC   = (RB_BIT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DIV_W        = 16;

  // Register byte offsets.
  localparam logic [7:0] REG_STATUS   = 8'h00;
  localparam logic [7:0] REG_CTRL     = 8'h04;
  localparam logic [7:0] REG_PARAM_LO = 8'h08;
  localparam logic [7:0] REG_PARAM_HI = 8'h0C;
  localparam logic [7:0] REG_SERIAL   = 8'h10;
  localparam logic [7:0] REG_FID      = 8'h14;
  localparam logic [7:0] REG_CHECK    = 8'h18;
  localparam int unsigned CTRL_RELOAD_BIT = 0;

  localparam int unsigned FIFO_DEPTH = 4;

  typedef logic [MEM_ROWS-1:0][MEM_COLS-1:0] mem_t;

  typedef enum {EX_IDLE, EX_DUMP} exec_e;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

endpackage : eeprom_pkg

// ---- tb/programmer_model.sv ----
`timescale 1ns/100ps

module programmer_model (
  input  wire logic pclk,
  output logic      supply_prog_det,
  output logic      pin_above_high,
  output logic      pin_below_low
);
  initial begin
    supply_prog_det = 1'b0;
    pin_above_high  = 1'b0;
    pin_below_low   = 1'b0;
  end

  // Raises or drops the supply to the programming level.
  task automatic set_supply(input logic on);
    @(posedge pclk);
    supply_prog_det <= on;
  endtask : set_supply

  // Every bit leaves the middle level, so the stream carries its own clock.
  task automatic send_frame(input logic [1:0] op, input logic [6:0] row, input logic [1:0] col, input logic d);
    logic [11:0] f;
    f = {op, row, col, d};
    for (int i = 11; i >= 0; i--) begin
      repeat (3) @(posedge pclk);
      pin_above_high <= f[i];
      pin_below_low  <= ~f[i];
      repeat (3) @(posedge pclk);
      pin_above_high <= 1'b0;
      pin_below_low  <= 1'b0;
    end
    repeat (6) @(posedge pclk);
  endtask : send_frame
endmodule : programmer_model

// ---- tb/eeprom_majority_parity_lock_bench.sv ----
`timescale 1ns/100ps

module eeprom_majority_parity_lock_bench;
  localparam logic [31:0] FID = 32'h2468_ACE1; // Arbitrary value.
  localparam int unsigned RB  = 4;
  logic                  pclk;
  logic                  presetn;
  eeprom_pkg::apb_req_s  req;
  eeprom_pkg::apb_rsp_s  rsp;
  logic                  sup;
  logic                  hi;
  logic                  lo;
  logic                  cur;
  logic                  prog;
  logic                  diag;
  logic                  diag_hi;
  logic [1:0]            amp;
  logic [63:0]           pw;
  logic [31:0]           d;
  logic                  err;
  int                    n_mismatch;
  int                    compares;
  int                    cycles;
  int                    hi_cnt;
  int                    base;

  eeprom_majority_parity_lock #(.FACTORY_ID_INIT(FID), .RB_BIT_CYCLES(RB)) eeprom_majority_parity_lock_i (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .supply_prog_det(sup),
    .pin_above_high(hi), .pin_below_low(lo), .supply_current_mod(cur), .prog_mode(prog),
    .out_diag_active(diag), .out_diag_high(diag_hi), .out_amp_mode(amp), .param_word(pw));
  programmer_model programmer_model_i (.pclk(pclk), .supply_prog_det(sup), .pin_above_high(hi), .pin_below_low(lo));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////

  task automatic final_report();
    if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cur === 1'b1) hi_cnt <= hi_cnt + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      final_report();
    end
  end

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1) @(posedge pclk);
    d   = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wait_prog(input logic v);
    for (int i = 0; i < 50 && prog !== v; i++) @(posedge pclk);
    chk("prog_mode", v, prog);
  endtask : wait_prog

  // Each entry is {row, column, data} of one cell write.
  task automatic session(input logic [9:0] fr [4], input int n);
    programmer_model_i.set_supply(1'b1);
    wait_prog(1'b1);
    for (int i = 0; i < n; i++)
      programmer_model_i.send_frame(eeprom_pkg::OP_WRITE, fr[i][9:3], fr[i][2:1], fr[i][0]);
    programmer_model_i.set_supply(1'b0);
    wait_prog(1'b0);
    repeat (6) @(posedge pclk);
  endtask : session

  ////////////////////////////////////////////////////////////////////////////////

  initial begin
    req = '0;
    presetn = 1'b0;
    n_mismatch = 0;
    compares = 0;
    cycles = 0;
    hi_cnt = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("param_word", eeprom_pkg::PARAM_RESET, pw);
    chk("amp_mode", 64'h1, amp);
    chk("diag", 64'h0, diag);
    apb(1'b0, eeprom_pkg::REG_FID, 32'h0);
    chk("fid", FID, d);
    chk("fid_err", 64'h0, err);
    apb(1'b0, eeprom_pkg::REG_CHECK, 32'h0);
    chk("check_bits", 64'h0, d);
    apb(1'b0, eeprom_pkg::REG_PARAM_HI, 32'h0);
    chk("param_hi", eeprom_pkg::PARAM_RESET[63:32], d);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", 64'h1, err);
    apb(1'b1, eeprom_pkg::REG_STATUS, 32'h0);
    chk("ro_write_err", 64'h1, err);
    // Whole-memory read back before any write.
    programmer_model_i.set_supply(1'b1);
    wait_prog(1'b1);
    base = hi_cnt;
    programmer_model_i.send_frame(eeprom_pkg::OP_READ, 7'h00, 2'h0, 1'b0);
    apb(1'b0, eeprom_pkg::REG_STATUS, 32'h0);
    chk("rb_busy", 64'h1, d[3]);
    for (int i = 0; i < 1500 && d[3] !== 1'b0; i++) apb(1'b0, eeprom_pkg::REG_STATUS, 32'h0);
    chk("rb_cur_cycles", (3 * $countones(eeprom_pkg::PARAM_RESET) + $countones(FID)) * RB, hi_cnt - base);
    programmer_model_i.set_supply(1'b0);
    wait_prog(1'b0);
    // Serial cell plus one flipped parameter cell: vote still holds.
    session('{{7'h05, 2'h3, 1'h1}, {7'h02, 2'h0, 1'h0}, 10'h0, 10'h0}, 2);
    chk("one_flip_params", eeprom_pkg::PARAM_RESET, pw);
    chk("one_flip_diag", 64'h0, diag);
    apb(1'b0, eeprom_pkg::REG_SERIAL, 32'h0);
    chk("serial", 64'h20, d);
    // Two cells of the fault level bit flipped: parity fault, high rail.
    session('{{7'h00, 2'h0, 1'h1}, {7'h00, 2'h1, 1'h1}, 10'h0, 10'h0}, 2);
    chk("fault_lev_bit", 64'h1, pw[0]);
    chk("diag_active", 64'h1, diag);
    chk("diag_high", 64'h1, diag_hi);
    apb(1'b1, eeprom_pkg::REG_CTRL, 32'h1);
    repeat (4) @(posedge pclk);
    chk("diag_hold", 64'h1, diag);
    // Fault level back to 0 with another odd parity word: low rail.
    session('{{7'h00, 2'h0, 1'h0}, {7'h00, 2'h1, 1'h0}, {7'h04, 2'h0, 1'h1}, {7'h04, 2'h1, 1'h1}}, 4);
    chk("diag_active_lo", 64'h1, diag);
    chk("diag_low", 64'h0, diag_hi);
    apb(1'b0, eeprom_pkg::REG_PARAM_LO, 32'h0);
    chk("param_lo", 64'h14, d);
    // Lock set first; the following write must be dropped.
    session('{{7'h01, 2'h0, 1'h1}, {7'h01, 2'h1, 1'h1}, {7'h05, 2'h3, 1'h0}, 10'h0}, 3);
    chk("clean_reload_diag", 64'h0, diag);
    apb(1'b0, eeprom_pkg::REG_STATUS, 32'h0);
    chk("lock_status", 64'h1, d[2]);
    apb(1'b0, eeprom_pkg::REG_SERIAL, 32'h0);
    chk("locked_serial", 64'h20, d);
    programmer_model_i.set_supply(1'b1);
    repeat (10) @(posedge pclk);
    chk("locked_entry", 64'h0, prog);
    // Locked read back: ten cells are set besides the identifier, the serial cell the dropped write left at 1 among them.
    base = hi_cnt;
    programmer_model_i.send_frame(eeprom_pkg::OP_READ, 7'h00, 2'h0, 1'b0);
    apb(1'b0, eeprom_pkg::REG_STATUS, 32'h0);
    chk("locked_rb_busy", 64'h1, d[3]);
    for (int i = 0; i < 1500 && d[3] !== 1'b0; i++) apb(1'b0, eeprom_pkg::REG_STATUS, 32'h0);
    chk("locked_rb_cycles", (10 + $countones(FID)) * RB, hi_cnt - base);
    chk("locked_rb_prog", 64'h0, prog);
    programmer_model_i.set_supply(1'b0);
    repeat (4) @(posedge pclk);
    // A reset in mid-run restores the factory image, so programming entry works again.
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("rst_params", eeprom_pkg::PARAM_RESET, pw);
    chk("rst_diag", 64'h0, diag);
    programmer_model_i.set_supply(1'b1);
    wait_prog(1'b1);
    programmer_model_i.set_supply(1'b0);
    wait_prog(1'b0);
    final_report();
  end
endmodule : eeprom_majority_parity_lock_bench
